// ### verilog/swecd_defines.vh
// Constants for the SPI write, protect and erase command decoder
// Functional notes
// - CMD24 writes one block, busy response
// - CMD25 writes blocks until stop or count
// - CMD27 programs writable config bits, busy
// - CMD28 sets group protect bit, busy
// - Protect group sized by low four bits of config field
// - CMD29 clears group protect bit, busy
// - CMD30 plain response with protect status in same cycle
// - CMD32 latches first erase sector
// - CMD33 latches last sector only; CMD32 alone selects a single sector
// - CMD34 drops one selected sector
// - CMD35 latches first erase group
// - CMD36 latches last erase group
// - CMD37 drops one selected group
// - CMD38 erases selection, busy response
// - Block length from latest CMD16
// - Block count from CMD23, next only
// - Index field decoded as plain binary
`ifndef SWECD_DEFINES_VH
`define SWECD_DEFINES_VH
`define SWECD_FRAME_W      48
`define SWECD_IDX_HI       45
`define SWECD_IDX_LO       40
`define SWECD_ARG_HI       39
`define SWECD_ARG_LO       8
`define SWECD_CMD_BLKLEN   6'h10
`define SWECD_CMD_BLKCNT   6'h17
`define SWECD_CMD_WR1      6'h18
`define SWECD_CMD_WRN      6'h19
`define SWECD_CMD_R26      6'h1a
`define SWECD_CMD_PCFG     6'h1b
`define SWECD_CMD_SETWP    6'h1c
`define SWECD_CMD_CLRWP    6'h1d
`define SWECD_CMD_QWP      6'h1e
`define SWECD_CMD_R31      6'h1f
`define SWECD_CMD_SECS     6'h20
`define SWECD_CMD_SECE     6'h21
`define SWECD_CMD_SECU     6'h22
`define SWECD_CMD_GRPS     6'h23
`define SWECD_CMD_GRPE     6'h24
`define SWECD_CMD_GRPU     6'h25
`define SWECD_CMD_ERASE    6'h26
`define SWECD_CMD_R39      6'h27
`define SWECD_BLKLEN_RST   32'h00000200
`define SWECD_WPSZ_RST     5'h00
`define SWECD_WPGRP_N      16
`define SWECD_RSP_ILLEGAL  8'h04
`define SWECD_RSP_OK       8'h00
`endif

// ### verilog/swecd_decoder.v
// SPI write, protect and erase command decoder with link sampling
`timescale 1ns/1ns
`include "swecd_defines.vh"
module swecd_decoder
(
	input  wire        clock,
	input  wire        resetn,
	input  wire        link_sclk,
	input  wire        link_cs_n,
	input  wire        link_mosi,
	input  wire        block_done,
	input  wire        stop_token,
	input  wire        op_done,
	input  wire [15:0] config_wr_bits,
	input  wire [4:0]  protect_group_size_field,
	output reg  [7:0]  resp_byte,
	output reg         resp_valid,
	output reg         resp_busy,
	output reg         write_start,
	output reg         write_multi,
	output reg  [31:0] write_addr,
	output reg  [31:0] block_length,
	output reg  [15:0] block_count,
	output reg         program_card_config_cmd,
	output reg  [15:0] card_config_bits,
	output reg  [15:0] protect_bits,
	output reg         protect_status_valid,
	output reg         erase_start,
	output reg  [31:0] erase_first,
	output reg  [31:0] erase_last,
	output reg         erase_by_group,
	output reg  [31:0] untag_addr,
	output reg         untag_valid
);
	localparam ST_IDLE  = 3'b001;
	localparam ST_BUSY  = 3'b010;
	localparam ST_MULTI = 3'b100;

	// Protect group index: shift by 9 plus the low four bits of the group size field
	function [3:0] grp_of;
		input [31:0] a;
		input [4:0]  sz;
		reg   [31:0] s;
		begin
			s = a >> (5'd9 + {1'b0, sz[3:0]});
			grp_of = s[3:0];
		end
	endfunction

	reg        sclk_m_r, sclk_s_r, sclk_d_r;
	reg        cs_m_r, cs_s_r;
	reg        mosi_m_r, mosi_s_r;
	reg [47:0] shift_r;
	reg [5:0]  nbits_r;
	reg [2:0]  state_r;
	reg        cnt_arm_r;
	reg [15:0] remain_r;
	wire       rise = sclk_s_r & ~sclk_d_r;
	wire [47:0] frm = {shift_r[46:0], mosi_s_r};
	wire [5:0]  idx = frm[`SWECD_IDX_HI:`SWECD_IDX_LO];
	wire [31:0] arg = frm[`SWECD_ARG_HI:`SWECD_ARG_LO];
	wire        got = rise & ~cs_s_r & (nbits_r == 6'd47);

	always @(posedge clock)
	begin
		if (!resetn)
		begin
			sclk_m_r <= 1'b0;
			sclk_s_r <= 1'b0;
			sclk_d_r <= 1'b0;
			cs_m_r <= 1'b1;
			cs_s_r <= 1'b1;
			mosi_m_r <= 1'b1;
			mosi_s_r <= 1'b1;
		end
		else
		begin
			sclk_m_r <= link_sclk;
			sclk_s_r <= sclk_m_r;
			sclk_d_r <= sclk_s_r;
			cs_m_r <= link_cs_n;
			cs_s_r <= cs_m_r;
			mosi_m_r <= link_mosi;
			mosi_s_r <= mosi_m_r;
		end
	end

	always @(posedge clock)
	begin
		if (!resetn)
		begin
			shift_r <= 48'h0;
			nbits_r <= 6'h0;
		end
		else if (cs_s_r)
			nbits_r <= 6'h0;
		else if (rise)
		begin
			// Hunt for start bit zero; idle line is high between frames
			if (nbits_r == 6'h0 && mosi_s_r)
				nbits_r <= 6'h0;
			else if (nbits_r == 6'd47)
				nbits_r <= 6'h0;
			else
				nbits_r <= nbits_r + 6'h1;
			shift_r <= frm;
		end
	end

	always @(posedge clock)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			resp_byte <= `SWECD_RSP_OK;
			resp_valid <= 1'b0;
			resp_busy <= 1'b0;
			write_start <= 1'b0;
			write_multi <= 1'b0;
			write_addr <= 32'h0;
			block_length <= `SWECD_BLKLEN_RST;
			block_count <= 16'h0;
			cnt_arm_r <= 1'b0;
			remain_r <= 16'h0;
			program_card_config_cmd <= 1'b0;
			card_config_bits <= 16'h0;
			protect_bits <= 16'h0;
			protect_status_valid <= 1'b0;
			erase_start <= 1'b0;
			erase_first <= 32'h0;
			erase_last <= 32'h0;
			erase_by_group <= 1'b0;
			untag_addr <= 32'h0;
			untag_valid <= 1'b0;
		end
		else
		begin
			resp_valid <= 1'b0;
			write_start <= 1'b0;
			program_card_config_cmd <= 1'b0;
			protect_status_valid <= 1'b0;
			erase_start <= 1'b0;
			untag_valid <= 1'b0;
			case (state_r)
			ST_IDLE:
			begin
				if (got)
				begin
					resp_valid <= 1'b1;
					resp_byte <= `SWECD_RSP_OK;
					case (idx)
					`SWECD_CMD_BLKLEN: block_length <= arg;
					`SWECD_CMD_BLKCNT:
					begin
						block_count <= arg[15:0];
						cnt_arm_r <= 1'b1;
					end
					`SWECD_CMD_WR1:
					begin
						write_addr <= arg;
						write_start <= 1'b1;
						write_multi <= 1'b0;
						resp_busy <= 1'b1;
						state_r <= ST_BUSY;
					end
					`SWECD_CMD_WRN:
					begin
						write_addr <= arg;
						write_start <= 1'b1;
						write_multi <= 1'b1;
						remain_r <= cnt_arm_r ? block_count : 16'h0;
						cnt_arm_r <= 1'b0;
						resp_busy <= 1'b1;
						state_r <= ST_MULTI;
					end
					`SWECD_CMD_PCFG:
					begin
						card_config_bits <= config_wr_bits;
						program_card_config_cmd <= 1'b1;
						resp_busy <= 1'b1;
						state_r <= ST_BUSY;
					end
					`SWECD_CMD_SETWP, `SWECD_CMD_CLRWP:
					begin
						protect_bits[grp_of(arg, protect_group_size_field)] <=
							(idx == `SWECD_CMD_SETWP);
						resp_busy <= 1'b1;
						state_r <= ST_BUSY;
					end
					`SWECD_CMD_QWP: protect_status_valid <= 1'b1;
					`SWECD_CMD_SECS, `SWECD_CMD_GRPS:
					begin
						erase_first <= arg;
						erase_last <= arg;
						erase_by_group <= (idx == `SWECD_CMD_GRPS);
					end
					`SWECD_CMD_SECE, `SWECD_CMD_GRPE: erase_last <= arg;
					`SWECD_CMD_SECU, `SWECD_CMD_GRPU:
					begin
						untag_addr <= arg;
						untag_valid <= 1'b1;
					end
					`SWECD_CMD_ERASE:
					begin
						erase_start <= 1'b1;
						resp_busy <= 1'b1;
						state_r <= ST_BUSY;
					end
					`SWECD_CMD_R26, `SWECD_CMD_R31, `SWECD_CMD_R39:
						resp_byte <= `SWECD_RSP_ILLEGAL;
					default: resp_valid <= 1'b0;
					endcase
				end
			end
			ST_BUSY:
			begin
				// Frames during busy are dropped; host must wait
				if (op_done)
				begin
					resp_busy <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			ST_MULTI:
			begin
				if (stop_token || (block_done && remain_r == 16'h1))
					state_r <= ST_BUSY;
				else if (block_done && remain_r != 16'h0)
					remain_r <= remain_r - 16'h1;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// ### testbench/swecd_checker.sv
// Port checker for the command decoder
`timescale 1ns/1ns
module swecd_checker
(
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [7:0] resp_byte,
	input wire logic       resp_valid,
	input wire logic       resp_busy,
	input wire logic       write_start,
	input wire logic       op_done,
	input wire logic       erase_start,
	input wire logic       program_card_config_cmd
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_write_busy: assert property (write_start |-> resp_busy && resp_valid) else $error("wr");
	a_erase_busy: assert property (erase_start |-> resp_busy && resp_valid) else $error("er");
	a_cfg_busy: assert property (program_card_config_cmd |-> resp_busy) else $error("cf");
	a_busy_end: assert property (resp_busy && op_done |-> ##[1:2] !resp_busy) else $error("be");
	a_busy_hold: assert property (resp_busy && !op_done |=> resp_busy) else $error("bh");
	a_rsp_pulse: assert property (resp_valid |=> !resp_valid) else $error("rp");
	a_busy_ok: assert property ($rose(resp_busy) |-> resp_byte == 8'h00) else $error("bo");
	a_bad_idle: assert property (resp_valid && resp_byte == 8'h04 |-> !resp_busy) else $error("bi");
	c_write: cover property (write_start);
	c_erase: cover property (erase_start);
	c_bad: cover property (resp_valid && resp_byte == 8'h04);
endmodule
bind swecd_decoder swecd_checker u_chk(.clock, .resetn, .resp_byte, .resp_valid, .resp_busy,
	.write_start, .op_done, .erase_start, .program_card_config_cmd);

// ### testbench/swecd_host_model.sv
// Host side that shifts command frames onto the link
`timescale 1ns/1ns
module swecd_host_model
(
	output logic link_sclk,
	output logic link_cs_n,
	output logic link_mosi
);
	// Clock idles low between frames, data line pulled high
	initial
	begin
		link_sclk = 0;
		link_cs_n = 1;
		link_mosi = 1;
	end
	task automatic send(input logic [5:0] idx, input logic [31:0] arg);
		logic [47:0] f;
		f = {2'b01, idx, arg, 7'h00, 1'b1};
		link_cs_n = 0;
		for (int i = 47; i >= 0; i--)
		begin
			link_mosi = f[i];
			#400 link_sclk = 1;
			#400 link_sclk = 0;
		end
		link_mosi = 1;
		#400 link_cs_n = 1;
		// Deselect gap so back-to-back frames see chip select high
		#400;
	endtask
endmodule

// ### testbench/swecd_decoder_tb.sv
// Scenario bench for the command decoder
`timescale 1ns/1ns
module swecd_decoder_tb;
	logic clock, resetn, link_sclk, link_cs_n, link_mosi, block_done, stop_token, op_done;
	logic resp_valid, resp_busy, write_start, write_multi, program_card_config_cmd;
	logic protect_status_valid, erase_start, erase_by_group, untag_valid;
	logic [4:0] protect_group_size_field;
	logic [7:0] resp_byte;
	logic [15:0] config_wr_bits, block_count, card_config_bits, protect_bits;
	logic [31:0] write_addr, block_length, erase_first, erase_last, untag_addr;
	logic [4:0] act;
	int error_cnt = 0;
	int samples_checked = 0;
	swecd_decoder u_swecd_decoder(.clock, .resetn, .link_sclk, .link_cs_n, .link_mosi,
		.block_done, .stop_token, .op_done, .config_wr_bits, .protect_group_size_field,
		.resp_byte, .resp_valid, .resp_busy, .write_start, .write_multi, .write_addr,
		.block_length, .block_count, .program_card_config_cmd, .card_config_bits,
		.protect_bits, .protect_status_valid, .erase_start, .erase_first, .erase_last,
		.erase_by_group, .untag_addr, .untag_valid);
	swecd_host_model u_swecd_host_model(.link_sclk, .link_cs_n, .link_mosi);
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Action pulses stand one cycle, so they are caught with the response
	task cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] rsp);
		act = 5'h00;
		fork
			u_swecd_host_model.send(idx, arg);
			begin
				repeat (500)
				begin
					@(negedge clock);
					if (resp_valid === 1'b1)
					begin
						act = {write_start, program_card_config_cmd, protect_status_valid,
							erase_start, untag_valid};
						break;
					end
				end
				chk({resp_valid, resp_byte}, {1'b1, rsp});
			end
		join
	endtask
	// Select order is block_done, stop_token, op_done
	task pulse(input logic [2:0] sel);
		@(negedge clock) {block_done, stop_token, op_done} = sel;
		@(negedge clock) {block_done, stop_token, op_done} = 3'h0;
	endtask
	task done;
		chk(resp_busy, 1);
		pulse(3'h1);
		@(negedge clock);
		chk(resp_busy, 0);
	endtask
	task t_write;
		cmd(6'h10, 32'h40, 8'h00);
		chk(block_length, 32'h40);
		cmd(6'h18, 32'h1200, 8'h00);
		chk({act, write_addr}, {5'h10, 32'h1200});
		done;
	endtask
	task t_multi;
		cmd(6'h17, 32'h3, 8'h00);
		cmd(6'h19, 32'h800, 8'h00);
		chk({write_multi, block_count}, {1'b1, 16'h3});
		repeat (3) pulse(3'h4);
		done;
		cmd(6'h19, 32'ha00, 8'h00);
		chk({act, block_count}, {5'h10, 16'h3});
		// Count was used up, so blocks alone never end this transfer
		repeat (4) pulse(3'h4);
		chk(resp_busy, 1);
		pulse(3'h2);
		done;
		// Multi flag holds until the next write command
		chk(write_multi, 1);
	endtask
	task t_prot;
		protect_group_size_field = 5'h1;
		cmd(6'h1c, 32'h1800, 8'h00);
		chk(protect_bits, 16'h0040);
		done;
		cmd(6'h1d, 32'h1800, 8'h00);
		chk(protect_bits, 0);
		done;
		cmd(6'h1e, 32'h1800, 8'h00);
		chk({act, protect_bits}, {5'h04, 16'h0});
	endtask
	task t_erase;
		cmd(6'h20, 32'h200, 8'h00);
		cmd(6'h21, 32'h600, 8'h00);
		chk({erase_first, erase_last}, {32'h200, 32'h600});
		cmd(6'h22, 32'h400, 8'h00);
		chk({act, untag_addr}, {5'h01, 32'h400});
		cmd(6'h26, 32'hffff, 8'h00);
		chk(act, 5'h02);
		done;
		cmd(6'h23, 32'h4000, 8'h00);
		cmd(6'h24, 32'h8000, 8'h00);
		chk({erase_by_group, erase_first}, {1'b1, 32'h4000});
		chk(erase_last, 32'h8000);
		cmd(6'h25, 32'hc000, 8'h00);
		chk({act, untag_addr}, {5'h01, 32'hc000});
	endtask
	task t_misc;
		config_wr_bits = 16'h5a5a;
		cmd(6'h1b, 32'h0, 8'h00);
		chk({act, card_config_bits}, {5'h08, 16'h5a5a});
		done;
		cmd(6'h1a, 0, 8'h04);
		cmd(6'h1f, 0, 8'h04);
		cmd(6'h27, 0, 8'h04);
		chk({act, resp_busy}, {5'h00, 1'b0});
	endtask
	task print_verdict;
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		{resetn, block_done, stop_token, op_done} = 0;
		config_wr_bits = 0;
		protect_group_size_field = 0;
		repeat (10) @(negedge clock);
		resetn = 1;
		chk(block_length, 32'h200);
		t_write;
		t_multi;
		t_prot;
		t_erase;
		t_misc;
		print_verdict;
	end
	initial
	begin
		#3000000;
		error_cnt++;
		print_verdict;
	end
endmodule
